// ===== src/gpio_bank_pkg.sv
// Constants, masks and line positions shared by the port bank files.
// Assumes a single system clock and the CPU driving plain access strobes.
// How it works
// RQ1 - Every port line except port 8 line 5 has its own software-written direction bit.
// RQ2 - Pull-up selects come in groups of four adjacent lines.
// RQ3 - Direction 1 means output, direction 0 means input.
// RQ4 - Port 8 line 5 is input only, no pull-up, no direction bit.
// RQ5 - Reading port 8 line 5 returns the shared interrupt pin level.
// RQ6 - The input-only line has no writable direction; always input.
// RQ7 - Software clears direction before peripheral input or analog output use.
// RQ8 - Peripheral output use drives the pin whatever the direction bit says.
// RQ9 - Each pin belongs to the port, a peripheral, or the bus controller.
// RQ10 - In external bus modes, direction writes to bus pins are ignored.
// RQ11 - Input lines read the pin; writes still load the latch.
// RQ12 - Output lines read the latch; writes load the latch.
// RQ13 - An output line drives its latch value onto the pin.
// RQ14 - Register bit n belongs to line n of the same port.
// RQ15 - An enabled analog output channel removes its line's pull-up.
// RQ16 - Pull-up only while group select is 1 and line is input.
// RQ17 - In external bus modes, ports 0-3, 4 low half, 5 get no pull-ups.
// RQ18 - Latch readback select makes port 1 reads return its latch.
// RQ19 - Upper ports enable low holds ports 11 to 14 data cleared.
// RQ20 - Reset clears all direction bits, so every line starts as input.
// RQ21 - Pin levels pass a two-stage synchroniser before the read path.
package gpio_bank_pkg;
	localparam int NUM_PORTS = 15;
	localparam int PORT_W = 8;
	localparam int GROUP_W = 4;
	localparam int NUM_LINES = NUM_PORTS * PORT_W;
	localparam int NUM_GROUPS = NUM_LINES / GROUP_W;
	localparam int PORT_SEL_W = 4;
	localparam int NMI_PORT = 8;
	localparam int NMI_BIT = 5;
	localparam int NMI_LINE = NMI_PORT * PORT_W + NMI_BIT;
	localparam logic [PORT_W-1:0] NMI_MASK = 8'h20;
	localparam logic [PORT_W-1:0] NO_MASK = 8'h00;
	localparam int READBACK_PORT = 1;
	localparam int UPPER_FIRST = 11;
	localparam int UPPER_LAST = 14;
	localparam int NUM_DA = 2;
	// Lines carrying analog output channels 0 and 1
	localparam int DA_LINE0 = 9 * PORT_W + 3;
	localparam int DA_LINE1 = 9 * PORT_W + 4;
	localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
	localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
	localparam logic [PORT_W-1:0] CLEAR_VAL = 8'h00;
	localparam logic [NUM_LINES-1:0] LINE_RST = '0;
	localparam logic [NUM_LINES-1:0] OE_N_RST = '1;
	// Lines whose pull-ups are lost in external bus modes, port 14 first
	localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PU_BUS_MASK = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
endpackage

// ===== src/port_slice.sv
// One 8-line port: direction, output latch, pin synchroniser and read value.
// Assumes the top decodes strobes and supplies the protect mask.
`timescale 1ns/100ps
module port_slice #(
	parameter logic [gpio_bank_pkg::PORT_W-1:0] FIXED_MASK = 8'h00
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Access
	input wire logic wr_dir_i,
	input wire logic wr_data_i,
	input wire logic [gpio_bank_pkg::PORT_W-1:0] wdata_i,
	input wire logic [gpio_bank_pkg::PORT_W-1:0] protect_i,
	input wire logic force_clear_i,
	input wire logic readback_i,
	// Pins
	input wire logic [gpio_bank_pkg::PORT_W-1:0] pin_i,
	// State
	output logic [gpio_bank_pkg::PORT_W-1:0] dir_o,
	output logic [gpio_bank_pkg::PORT_W-1:0] latch_o,
	output logic [gpio_bank_pkg::PORT_W-1:0] sync_o,
	output logic [gpio_bank_pkg::PORT_W-1:0] rd_val_o
);
	import gpio_bank_pkg::*;

	logic [PORT_W-1:0] sync1;
	logic [PORT_W-1:0] keep;
	logic [PORT_W-1:0] next_dir;
	logic [PORT_W-1:0] next_latch;

	// Fixed input lines and protected lines keep their old value
	assign keep = protect_i | FIXED_MASK;
	assign next_dir = wr_dir_i ? ((wdata_i & ~keep) | (dir_o & protect_i)) & ~FIXED_MASK
		: dir_o & ~FIXED_MASK; // RQ1 RQ6 RQ10 RQ14
	assign next_latch = force_clear_i ? CLEAR_VAL
		: wr_data_i ? ((wdata_i & ~keep) | (latch_o & protect_i)) & ~FIXED_MASK
		: latch_o; // RQ11 RQ12 RQ19
	// Output lines read the latch, input lines the synchronised pin
	assign rd_val_o = force_clear_i ? CLEAR_VAL
		: readback_i ? latch_o
		: (dir_o & latch_o) | (~dir_o & sync_o); // RQ3 RQ5 RQ11 RQ12 RQ18

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dir_o <= DIR_RST; // RQ20
			latch_o <= LATCH_RST;
			sync1 <= LATCH_RST;
			sync_o <= LATCH_RST;
		end else begin
			dir_o <= next_dir;
			latch_o <= next_latch;
			sync1 <= pin_i; // RQ21
			sync_o <= sync1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_pin_steady;
		$stable(pin_i) [*3];
	endsequence

	a_dir_write: assert property (wr_dir_i |=> ((dir_o & ~$past(protect_i)) == // RQ1
		($past(wdata_i) & ~$past(protect_i) & ~FIXED_MASK)))
		else $error("direction write not stored");
	a_dir_protect: assert property (wr_dir_i |=> ((dir_o & $past(protect_i)) == // RQ10
		($past(dir_o) & $past(protect_i))))
		else $error("protected direction bit changed");
	a_fixed_input: assert property ((dir_o & FIXED_MASK) == NO_MASK) // RQ6
		else $error("input-only line has direction set");
	a_latch_clear: assert property (force_clear_i |=> (latch_o == CLEAR_VAL)) // RQ19
		else $error("disabled upper port latch not cleared");
	a_out_read: assert property (!force_clear_i |-> ((rd_val_o & dir_o) == // RQ12
		(latch_o & dir_o)))
		else $error("output line read not from latch");
	// Synchroniser needs two edges out of reset before it shows the pin
	a_pin_sync: assert property ((s_pin_steady ##0 (!force_clear_i && !readback_i && // RQ21
		!$past(rst_i) && !$past(rst_i, 2)))
		|-> ((rd_val_o & ~dir_o) == (pin_i & ~dir_o)))
		else $error("input line read does not follow pin");
endmodule

// ===== src/gpio_port_bank.sv
// Top of the port bank: strobe decode, pin ownership, pull-ups, read path.
// Assumes plain CPU strobes on clk_i and peripherals or bus driving their own masks.
`timescale 1ns/100ps
module gpio_port_bank (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// CPU access
	input wire logic [gpio_bank_pkg::PORT_SEL_W-1:0] acc_port_i,
	input wire logic wr_dir_i,
	input wire logic wr_data_i,
	input wire logic [gpio_bank_pkg::PORT_W-1:0] wdata_i,
	output logic [gpio_bank_pkg::PORT_W-1:0] rd_data_o,
	output logic [gpio_bank_pkg::PORT_W-1:0] rd_dir_o,
	// Configuration
	input wire logic [gpio_bank_pkg::NUM_GROUPS-1:0] pullup_select_i,
	input wire logic latch_readback_select_i,
	input wire logic upper_ports_enable_i,
	input wire logic ext_bus_mode_i,
	input wire logic [gpio_bank_pkg::NUM_DA-1:0] analog_out_enable_i,
	// Pin owners
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] bus_pin_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] bus_oe_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] bus_out_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] periph_oe_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] periph_out_i,
	// Pins
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] pin_i,
	output logic [gpio_bank_pkg::NUM_LINES-1:0] pin_o,
	output logic [gpio_bank_pkg::NUM_LINES-1:0] pin_oe_n_o,
	output logic [gpio_bank_pkg::NUM_LINES-1:0] pullup_en_o,
	output logic [gpio_bank_pkg::NUM_LINES-1:0] pin_sync_o
);
	import gpio_bank_pkg::*;

	logic [NUM_PORTS-1:0][PORT_W-1:0] dir_all;
	logic [NUM_PORTS-1:0][PORT_W-1:0] latch_all;
	logic [NUM_PORTS-1:0][PORT_W-1:0] rd_all;
	logic [NUM_PORTS-1:0][PORT_W-1:0] sync_all;
	logic [NUM_LINES-1:0] dir_flat;
	logic [NUM_LINES-1:0] latch_flat;
	logic [NUM_LINES-1:0] own_bus;
	logic [NUM_LINES-1:0] own_per;
	logic [NUM_LINES-1:0] own_any;
	logic [NUM_LINES-1:0] next_pin;
	logic [NUM_LINES-1:0] next_oe_n;
	logic [NUM_LINES-1:0] next_pu;
	logic [NUM_LINES-1:0] group_sel;
	logic [NUM_LINES-1:0] bus_pu_mask;
	logic sel_valid;
	logic [PORT_W-1:0] next_rd;
	logic [PORT_W-1:0] next_rd_dir;

	assign dir_flat = dir_all;
	assign latch_flat = latch_all;
	assign pin_sync_o = sync_all;
	// Bus controller beats peripherals, peripherals beat the port
	assign own_bus = bus_pin_i & {NUM_LINES{ext_bus_mode_i}}; // RQ9
	assign own_per = periph_oe_i & ~own_bus; // RQ9
	assign own_any = own_bus | own_per;
	// Flat copy of the external-mode pull-up mask, line order
	assign bus_pu_mask = PU_BUS_MASK;

	// ----------------------------------------------------------------
	// Per-port storage
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic sel;
			logic clear;
			assign sel = (acc_port_i == PORT_SEL_W'(p));
			assign clear = (p >= UPPER_FIRST) && (p <= UPPER_LAST) &&
				!upper_ports_enable_i; // RQ19
			port_slice #(
				.FIXED_MASK((p == NMI_PORT) ? NMI_MASK : NO_MASK)
			) u_slice (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.wr_dir_i(wr_dir_i && sel),
				.wr_data_i(wr_data_i && sel),
				.wdata_i(wdata_i),
				.protect_i(own_bus[p*PORT_W +: PORT_W]), // RQ10
				.force_clear_i(clear),
				.readback_i((p == READBACK_PORT) && latch_readback_select_i), // RQ18
				.pin_i(pin_i[p*PORT_W +: PORT_W]),
				.dir_o(dir_all[p]),
				.latch_o(latch_all[p]),
				.sync_o(sync_all[p]),
				.rd_val_o(rd_all[p])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Per-line drive and pull-up
	// ----------------------------------------------------------------
	genvar l;
	generate
		for (l = 0; l < NUM_LINES; l++) begin : g_line
			localparam int LP = l / PORT_W;
			localparam int LB = l % PORT_W;
			logic analog;
			logic drive;
			assign analog = ((l == DA_LINE0) && analog_out_enable_i[0]) ||
				((l == DA_LINE1) && analog_out_enable_i[1]);
			assign drive = own_bus[l] ? bus_oe_i[l]
				: own_per[l] ? 1'b1 : dir_all[LP][LB]; // RQ3 RQ8
			assign next_oe_n[l] = !drive;
			assign next_pin[l] = own_bus[l] ? bus_out_i[l]
				: own_per[l] ? periph_out_i[l] : latch_all[LP][LB]; // RQ13
			assign group_sel[l] = pullup_select_i[l / GROUP_W]; // RQ2
			// Pull-up lost on any driven line, so it never fights an output
			assign next_pu[l] = group_sel[l] && !drive && !analog &&
				!(ext_bus_mode_i && bus_pu_mask[l]) &&
				(l != NMI_LINE); // RQ2 RQ4 RQ15 RQ16 RQ17
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	assign sel_valid = (acc_port_i < PORT_SEL_W'(NUM_PORTS));
	assign next_rd = sel_valid ? rd_all[acc_port_i] : CLEAR_VAL; // RQ14
	assign next_rd_dir = sel_valid ? dir_all[acc_port_i] : CLEAR_VAL;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= CLEAR_VAL;
			rd_dir_o <= DIR_RST;
			pin_o <= LINE_RST;
			pin_oe_n_o <= OE_N_RST;
			pullup_en_o <= LINE_RST;
		end else begin
			rd_data_o <= next_rd;
			rd_dir_o <= next_rd_dir;
			pin_o <= next_pin;
			pin_oe_n_o <= next_oe_n;
			pullup_en_o <= next_pu;
		end
	end

	// ----------------------------------------------------------------
	// Drive and pull-up checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Direction write while the bus controller may own some lines
	sequence s_bus_dir_write;
		ext_bus_mode_i && wr_dir_i && sel_valid;
	endsequence

	// Shared line held long enough to cross the synchroniser
	sequence s_nmi_settled;
		$stable(pin_i[NMI_LINE]) [*3] ##0 (!$past(rst_i) && !$past(rst_i, 2));
	endsequence

	a_latch_drive: assert property (1'b1 |=> ((pin_o & ~$past(own_any)) == // RQ13
		($past(latch_flat) & ~$past(own_any))))
		else $error("port-owned pin does not show latch");
	a_dir_drive: assert property (1'b1 |=> ((~pin_oe_n_o & ~$past(own_any)) == // RQ3
		($past(dir_flat) & ~$past(own_any))))
		else $error("port-owned pin drive differs from direction");
	a_periph_drive: assert property (1'b1 |=> ((~pin_oe_n_o & $past(own_per)) == // RQ8
		$past(own_per)))
		else $error("peripheral output pin not driven");
	a_periph_value: assert property (1'b1 |=> ((pin_o & $past(own_per)) == // RQ8
		($past(periph_out_i) & $past(own_per))))
		else $error("peripheral output value not on pin");
	a_bus_drive: assert property (1'b1 |=> ((pin_o & $past(own_bus)) == // RQ9
		($past(bus_out_i) & $past(own_bus))))
		else $error("bus-owned pin does not show bus value");
	a_bus_enable: assert property (1'b1 |=> ((~pin_oe_n_o & $past(own_bus)) == // RQ9
		($past(bus_oe_i) & $past(own_bus))))
		else $error("bus-owned pin drive differs from bus enable");
	a_bus_dir_hold: assert property (s_bus_dir_write |=> // RQ10
		((dir_flat & $past(own_bus)) == ($past(dir_flat) & $past(own_bus))))
		else $error("direction of bus-owned line changed");

	// A pull-up must never fight a driven line
	a_pullup_input: assert property (1'b1 |=> ((pullup_en_o & ~pin_oe_n_o) == // RQ16
		LINE_RST))
		else $error("pull-up on a driven line");
	a_group_pullup: assert property (1'b1 |=> ((pullup_en_o & ~$past(group_sel)) == // RQ2
		LINE_RST))
		else $error("pull-up outside a selected group");
	a_nmi_pullup: assert property (!pullup_en_o[NMI_LINE] && !dir_all[NMI_PORT][NMI_BIT]) // RQ4
		else $error("input-only line has pull-up or direction");
	a_analog_pullup: assert property (analog_out_enable_i[0] |=> !pullup_en_o[DA_LINE0]) // RQ15
		else $error("pull-up left on analog output line");
	a_analog1_pullup: assert property (analog_out_enable_i[1] |=> !pullup_en_o[DA_LINE1]) // RQ15
		else $error("pull-up left on second analog output line");
	a_bus_pullup: assert property (ext_bus_mode_i |=> !pullup_en_o[0]) // RQ17
		else $error("pull-up on bus port in external mode");
	a_bus_mask_pullup: assert property (ext_bus_mode_i |=> // RQ17
		((pullup_en_o & bus_pu_mask) == LINE_RST))
		else $error("pull-up on a masked line in external mode");

	// ----------------------------------------------------------------
	// Read path checks
	// ----------------------------------------------------------------
	// Reads show up one edge after the port is selected
	a_readback: assert property ((latch_readback_select_i && // RQ18
		acc_port_i == PORT_SEL_W'(READBACK_PORT)) |=>
		(rd_data_o == $past(latch_all[READBACK_PORT])))
		else $error("latch readback not returned");
	a_upper_clear: assert property ((!upper_ports_enable_i && // RQ19
		acc_port_i >= PORT_SEL_W'(UPPER_FIRST) && acc_port_i <= PORT_SEL_W'(UPPER_LAST)) |=>
		(rd_data_o == CLEAR_VAL))
		else $error("disabled upper port not read as zero");
	a_upper_latch: assert property (!upper_ports_enable_i |=> // RQ19
		(latch_all[UPPER_LAST] == CLEAR_VAL))
		else $error("last upper port latch not cleared");
	a_nmi_read: assert property ((s_nmi_settled ##0 // RQ5
		(acc_port_i == PORT_SEL_W'(NMI_PORT))) |=>
		(rd_data_o[NMI_BIT] == $past(pin_i[NMI_LINE])))
		else $error("shared interrupt line read differs from pin");
	a_nmi_dir_read: assert property ((acc_port_i == PORT_SEL_W'(NMI_PORT)) |=> // RQ6
		!rd_dir_o[NMI_BIT])
		else $error("input-only line reads as output");
	a_bad_port_read: assert property (!sel_valid |=> // RQ14
		((rd_data_o == CLEAR_VAL) && (rd_dir_o == CLEAR_VAL)))
		else $error("missing port does not read as zero");
endmodule

// ===== testbench/pin_world.sv
// External parts hanging on every port line of the bank.
// Assumes the bank's registered drive, enable and pull-up outputs.
`timescale 1ns/100ps
module pin_world (
	// Clock
	input wire logic clk_i,
	// Bank side
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] drv_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] oe_n_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] pu_i,
	// Outside parts
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] ext_en_i,
	input wire logic [gpio_bank_pkg::NUM_LINES-1:0] ext_val_i,
	output logic [gpio_bank_pkg::NUM_LINES-1:0] pin_o
);
	import gpio_bank_pkg::*;
	logic [NUM_LINES-1:0] noise = '0;
	always_ff @(posedge clk_i) begin
		noise <= ~noise;
	end
	// Nobody driving: pull-up level, else a pattern that never settles
	assign pin_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_val_i)
		| (oe_n_i & ~ext_en_i & (pu_i | noise));
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the port bank with random port traffic.
// Assumes the pin_world model closes every line.
`timescale 1ns/100ps
module testbench;
	import gpio_bank_pkg::*;
	logic clk_i = 0, rst_i = 1, wr_dir_i = 0, wr_data_i = 0, rbs = 0, upe = 1, ext = 0;
	logic [3:0] acc_port_i = 0;
	logic [7:0] wdata_i = 0, rd_data_o, rd_dir_o, d, v;
	logic [NUM_GROUPS-1:0] pus = '0;
	logic [1:0] dae = 0;
	logic [NUM_LINES-1:0] bpin = '0, boe = '0, bout = '0, poe = '0, pout = '0, ev = '0;
	logic [NUM_LINES-1:0] pin, pin_o, oe_n, pu, sync;
	logic [127:0] r;
	logic [3:0] p;
	int err_total = 0, compares = 0, seed;
	gpio_port_bank dut (.clk_i(clk_i), .rst_i(rst_i), .acc_port_i(acc_port_i),
		.wr_dir_i(wr_dir_i), .wr_data_i(wr_data_i), .wdata_i(wdata_i), .rd_data_o(rd_data_o),
		.rd_dir_o(rd_dir_o), .pullup_select_i(pus), .latch_readback_select_i(rbs),
		.upper_ports_enable_i(upe), .ext_bus_mode_i(ext), .analog_out_enable_i(dae),
		.bus_pin_i(bpin), .bus_oe_i(boe), .bus_out_i(bout), .periph_oe_i(poe),
		.periph_out_i(pout), .pin_i(pin), .pin_o(pin_o), .pin_oe_n_o(oe_n),
		.pullup_en_o(pu), .pin_sync_o(sync));
	pin_world world (.clk_i(clk_i), .drv_i(pin_o), .oe_n_i(oe_n), .pu_i(pu),
		.ext_en_i({NUM_LINES{1'b1}}), .ext_val_i(ev), .pin_o(pin));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	// Strobes stay up until the next wr or rd call, so no signal moves twice in a step
	task automatic wr(input logic [3:0] pt, input logic a, input logic b, input logic [7:0] x);
		acc_port_i = pt;
		wr_dir_i = a;
		wr_data_i = b;
		wdata_i = x;
		cyc(1);
	endtask
	task automatic rd(input logic [3:0] pt);
		wr_dir_i = 0;
		wr_data_i = 0;
		acc_port_i = pt;
		cyc(5);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	function automatic logic [7:0] exp_rd(logic [7:0] dr, logic [7:0] lt, logic [7:0] pn);
		return (dr & lt) | (~dr & pn);
	endfunction
	task automatic final_report();
		$display("checks %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		seed = $urandom(32'hA21D);
		cyc(2);
		rst_i = 0;
		cyc(1);
		for (int i = 0; i < NUM_PORTS; i++) begin
			rd(i[3:0]);
			chk("dir after reset", 8'h00, rd_dir_o);
			chk("oe_n after reset", 8'hFF, oe_n[i*8+:8]);
		end
		// Random traffic, back-to-back direction then data writes
		for (int k = 0; k < 40; k++) begin
			p = 4'($urandom_range(0, 14));
			d = 8'($urandom);
			v = 8'($urandom);
			r = {$urandom, $urandom, $urandom, $urandom};
			ev = r[NUM_LINES-1:0];
			wr(p, 1, 0, d);
			wr(p, 0, 1, v);
			rd(p);
			if (p == 4'(NMI_PORT)) d = d & ~NMI_MASK;
			chk("dir", d, rd_dir_o);
			chk("data", exp_rd(d, v, ev[p*8+:8]), rd_data_o);
			chk("pin", v & d, pin_o[p*8+:8] & d);
			chk("oe_n", ~d, oe_n[p*8+:8]);
			chk("sync", exp_rd(d, v, ev[p*8+:8]), sync[p*8+:8]);
		end
		wr(1, 1, 1, 8'h00);
		wr(1, 0, 1, 8'h96);
		rbs = 1;
		rd(1);
		chk("readback", 8'h96, rd_data_o);
		upe = 0;
		wr(12, 1, 1, 8'h5A);
		rd(12);
		chk("upper", 8'h00, rd_data_o);
		rd(15);
		chk("no port", 8'h00, rd_data_o);
		wr(6, 1, 0, 8'h3C);
		wr(9, 1, 0, 8'h00);
		wr(8, 1, 0, 8'h00);
		wr(10, 1, 0, 8'h00);
		rd(6);
		pus = '0;
		pus[13] = 1;
		cyc(3);
		chk("group pullup", 8'hC0, pu[48+:8]);
		pus = '1;
		dae = 2'b01;
		poe[80+:8] = 8'hFF;
		pout[80+:8] = 8'hA7;
		cyc(3);
		chk("analog pullup", 8'hF7, pu[72+:8]);
		chk("shared line pullup", 8'hDF, pu[64+:8]);
		chk("periph pin", 8'hA7, pin_o[80+:8]);
		chk("periph oe_n", 8'h00, oe_n[80+:8]);
		dae = 2'b10;
		cyc(3);
		chk("analog1 pullup", 8'hEF, pu[72+:8]);
		wr(0, 1, 0, 8'h00);
		ext = 1;
		bpin[7:0] = 8'hFF;
		boe[7:0] = 8'hFF;
		bout[7:0] = 8'h55;
		wr(0, 1, 0, 8'hFF);
		rd(0);
		chk("bus dir", 8'h00, rd_dir_o);
		chk("bus pin", 8'h55, pin_o[7:0]);
		chk("bus mode pullup", 8'h00, pu[40+:8]);
		chk("port6 pullup", 8'hC3, pu[48+:8]);
		final_report();
	end
endmodule
